// ---- test/afe_model.sv ----
// Comparator model of the analog front end behind the sequencer.
// Assumes a held input level that stays fixed for the whole run.
`timescale 1ns/1ps
module afe_model #(
    parameter logic [9:0] LEVEL = 10'h2A5
) (
    // Trial code from the sequencer
    input  wire logic [9:0] dac_code,
    // Comparator decision
    output logic            comp_in
);
    // A fixed level makes every completed result equal LEVEL.
    assign comp_in = (LEVEL >= dac_code);
endmodule : afe_model

// ---- test/sar_acq_ctrl_tb.sv ----
// Self-checking bench of the converter sequencer.
// Assumes one host at a time; the pin conversion clock runs free at
// one eighth of clk_sys so that both clock sources are exercised.
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        check_count++; \
        if ((a) !== (b)) begin \
            mismatches++; \
            $display("CHECK FAILED %0t value mismatch", $time); \
        end \
    end
module sar_acq_ctrl_tb;
    localparam logic [9:0] LVL = 10'h2A5;
    logic clk_sys, rst, cs_n, wr_n, rd_n, hbs, comp_in, track, d_oe;
    logic done_n, done_oe, pol, awv, awr, wv, wrr, bv, br, arv, arr;
    logic rv, rr, irq;
    logic [7:0] d_in, d_out;
    logic [9:0] dac;
    logic [1:0] bresp, rresp, r;
    logic [3:0] awa, ara;
    logic [2:0] cdiv;
    logic [31:0] wd, rdd, d;
    sar_pkg::route_t route;
    int mismatches, check_count, n;
    sar_acq_ctrl #(.INT_TICK_CYCLES(2)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .high_byte_select(hbs), .d_in(d_in), .d_out(d_out),
        .d_oe(d_oe), .done_n(done_n), .done_oe(done_oe),
        .conv_clk_in(cdiv[2]), .comp_in(comp_in), .track(track),
        .route(route), .polarity_select(pol), .dac_code(dac),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .irq(irq));
    afe_model #(.LEVEL(LVL)) u_afe (.dac_code(dac), .comp_in(comp_in));
    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Pin conversion clock; its top bit falls once every eight cycles.
    always @(posedge clk_sys) begin
        cdiv <= cdiv + 3'h1;
    end
    // Each bus wait gives up after a bounded count, so a hang ends as a failed check.
    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        bit ad, dd;
        ad = 0;
        dd = 0;
        n = 0;
        @(posedge clk_sys);
        awa <= a;
        wd  <= v;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awv && awr === 1'b1) begin
                ad = 1;
                awv <= 1'b0;
            end
            if (wv && wrr === 1'b1) begin
                dd = 1;
                wv <= 1'b0;
            end
        end while (!(ad && dd) && n < 50);
        while (bv !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        // A response that never came counts as a mismatch.
        `CHK(bv, 1'b1)
        r = bresp;
        br <= 1'b0;
    endtask : axw
    task automatic axr(input logic [3:0] a);
        n = 0;
        @(posedge clk_sys);
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 50);
        `CHK(rv, 1'b1)
        d = rdd;
        rr <= 1'b0;
    endtask : axr
    // Host write; the byte is taken at the edge that sees wr_n rise.
    task automatic hw(input logic [7:0] b);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        d_in <= b;
        @(posedge clk_sys);
        wr_n <= 1'b1;
        @(posedge clk_sys);
        cs_n <= 1'b1;
    endtask : hw
    task automatic hrd(input logic hb, input logic [7:0] e);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        hbs  <= hb;
        repeat (3) @(posedge clk_sys);
        `CHK(d_out, e)
        `CHK(d_oe, 1'b1)
        `CHK(done_oe, 1'b1)
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clk_sys);
    endtask : hrd
    task automatic cnt_while(input logic lvl);
        n = 0;
        while (track === lvl && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : cnt_while
    task automatic wdone;
        n = 0;
        while (done_n !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(done_n, 1'b0)
    endtask : wdone
    task automatic t_regs;
        axr(sar_pkg::MASK_OFS);
        `CHK(d[1:0], sar_pkg::MASK_RST)
        axw(sar_pkg::RESULT_OFS, 32'h0000_0001);
        `CHK(r, sar_pkg::RESP_SLVERR)
    endtask : t_regs
    task automatic t_int;
        hw(8'h98);
        @(posedge clk_sys);
        `CHK(track, 1'b1)
        `CHK(route.neg_com, 1'b1)
        `CHK(pol, 1'b1)
        cnt_while(1'b1);
        `CHK(n >= 5 && n <= 10, 1'b1)
        wdone();
        `CHK(n >= 24 && n <= 30, 1'b1)
        `CHK(irq, 1'b0)
        axw(sar_pkg::MASK_OFS, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        axw(sar_pkg::STATUS_OFS, 32'h0000_0003);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        hrd(1'b0, LVL[7:0]);
        `CHK(done_n, 1'b1)
        hrd(1'b1, {6'h00, LVL[9:8]});
    endtask : t_int
    task automatic t_ext;
        hw(8'hA2);
        @(posedge clk_sys);
        `CHK(route.pos, 3'h2)
        `CHK(route.neg, 3'h3)
        `CHK(route.neg_com, 1'b0)
        repeat (30) @(posedge clk_sys);
        `CHK(track, 1'b1)
        hw(8'h82);
        repeat (2) @(posedge clk_sys);
        `CHK(track, 1'b0)
        wdone();
        axr(sar_pkg::RESULT_OFS);
        `CHK(d[9:0], LVL)
    endtask : t_ext
    task automatic t_abort;
        hw(8'h90);
        cnt_while(1'b0);
        `CHK(done_n, 1'b1)
        cnt_while(1'b1);
        repeat (5) @(posedge clk_sys);
        hw(8'h90);
        @(posedge clk_sys);
        `CHK(track, 1'b1)
        `CHK(done_n, 1'b1)
        axr(sar_pkg::STATUS_OFS);
        `CHK(d[sar_pkg::ST_ABORT_BIT], 1'b1)
        // The partial code of the aborted run must not reach the result.
        axr(sar_pkg::RESULT_OFS);
        `CHK(d[9:0], LVL)
        `CHK(d[sar_pkg::BUSY_BIT], 1'b1)
        wdone();
        axr(sar_pkg::RESULT_OFS);
        `CHK(d[9:0], LVL)
    endtask : t_abort
    // External clock: four pin-clock falls to hold, thirteen to finish.
    task automatic t_xclk;
        hw(8'hD8);
        @(posedge clk_sys);
        `CHK(track, 1'b1)
        cnt_while(1'b1);
        `CHK(n >= 23 && n <= 30, 1'b1)
        wdone();
        `CHK(n, 104)
        axr(sar_pkg::RESULT_OFS);
        `CHK(d[9:0], LVL)
        `CHK(d[sar_pkg::BUSY_BIT], 1'b0)
    endtask : t_xclk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // Inputs start idle; reset is held for eight cycles.
    initial begin
        rst = 1'b1;
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        hbs = 1'b0;
        d_in = 8'h00;
        awv = 1'b0;
        wv = 1'b0;
        br = 1'b0;
        arv = 1'b0;
        rr = 1'b0;
        awa = 4'h0;
        ara = 4'h0;
        wd = 32'h0;
        cdiv = 3'h0;
        mismatches = 0;
        check_count = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_int();
        t_ext();
        t_abort();
        t_xclk();
        print_verdict();
    end
    // The whole run needs a few thousand cycles at most.
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
endmodule : sar_acq_ctrl_tb

// ---- verilog/sar_acq_ctrl.sv ----
// Acquisition and conversion sequencer of a 10-bit successive
// approximation converter with a byte-wide host port and AXI4-Lite status.
// Assumes host pins are synchronous to clk_sys and the analog comparator
// output settles within one conversion clock period.
//
// Contract
// - Write strobe rising edge starts tracking.
// - External mode: next write ends acquisition.
// - Internal mode: hold on fourth falling edge.
// - Conversion lasts thirteen conversion clocks.
// - Write during conversion aborts, restarts acquisition.
// - Cleared mode bit gives self-timed acquisition.
// - Result is ten bits, split eight plus two.
// - Single-ended uses common; differential uses pair.
// - Control bit five selects acquisition mode.
// - Done low at completion; read or write clears.
// - High byte select picks upper two bits.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module sar_acq_ctrl #(
    parameter int CONV_CYCLES     = sar_pkg::CONV_CYCLES,
    parameter int ACQ_FALL_EDGES  = sar_pkg::ACQ_FALL_EDGES,
    parameter int INT_TICK_CYCLES = sar_pkg::INT_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // Host parallel port
    input  wire logic                       cs_n,
    input  wire logic                       wr_n,
    input  wire logic                       rd_n,
    input  wire logic                       high_byte_select,
    input  wire logic [7:0]                 d_in,
    output logic      [7:0]                 d_out,
    output logic                            d_oe,
    output logic                            done_n,
    output logic                            done_oe,
    // External conversion clock pin
    input  wire logic                       conv_clk_in,
    // Analog front end
    input  wire logic                       comp_in,
    output logic                            track,
    output sar_pkg::route_t                 route,
    output logic                            polarity_select,
    output logic      [9:0]                 dac_code,
    // AXI4-Lite slave
    input  wire logic [sar_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic      [1:0]                 s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [sar_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic      [31:0]                s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Interrupt
    output logic                            irq
);

    localparam int CNT_W = 4;
    localparam int DIV_W = $clog2(INT_TICK_CYCLES + 1);

    // Refuse settings the counters or the SAR walk cannot serve.
    if (CONV_CYCLES <= sar_pkg::RESULT_BITS || CONV_CYCLES >= 16 ||
        ACQ_FALL_EDGES < 1 || ACQ_FALL_EDGES >= 16 ||
        INT_TICK_CYCLES < 1) begin : g_bad_param
        $error("sar_acq_ctrl: unsupported parameter values");
    end

    // Input multiplexer routing from the control byte.
    function automatic sar_pkg::route_t route_of(sar_pkg::ctl_byte_t c);
        sar_pkg::route_t r;
        r.pos     = c.chan;
        r.neg     = c.single_ended ? 3'h0 : (c.chan ^ 3'h1);
        r.neg_com = c.single_ended;
        return r;
    endfunction : route_of

    sar_pkg::state_t    state_reg, state_next;
    sar_pkg::ctl_byte_t ctl_reg, ctl_next;
    logic [CNT_W-1:0]   cnt_reg, cnt_next;
    logic [DIV_W-1:0]   div_reg, div_next;
    logic [9:0]         sar_reg, sar_next, bit_reg, bit_next;
    logic [9:0]         result_reg, result_next;
    logic               clk_ext_reg, clk_ext_next;
    logic               track_reg, track_next;
    logic               done_n_reg, done_n_next;
    logic               wr_n_q_reg, rd_n_q_reg, cclk_q_reg;
    logic               wr_rise, rd_fall, tick, conv_done, aborted;

    // Write strobe rise and read strobe fall, both qualified by select.
    assign wr_rise = ~wr_n_q_reg & wr_n & ~cs_n;
    assign rd_fall = rd_n_q_reg & ~rd_n & ~cs_n;
    // One tick per falling edge of the chosen conversion clock.
    assign tick = clk_ext_reg ? (cclk_q_reg & ~conv_clk_in)
                              : (div_reg == DIV_W'(INT_TICK_CYCLES - 1));

    // Sequencer next state.
    always_comb begin
        state_next   = state_reg;
        ctl_next     = ctl_reg;
        cnt_next     = cnt_reg;
        sar_next     = sar_reg;
        bit_next     = bit_reg;
        result_next  = result_reg;
        clk_ext_next = clk_ext_reg;
        track_next   = track_reg;
        conv_done    = 1'b0;
        aborted      = 1'b0;
        div_next     = tick && !clk_ext_reg ? '0 : DIV_W'(div_reg + 1'b1);
        if (wr_rise) begin
            ctl_next = sar_pkg::ctl_byte_t'(d_in);
            cnt_next = '0;
            // Power-down codes leave the clock mode as it was.
            if (d_in[7]) begin
                clk_ext_next = d_in[6];
            end
            if (state_reg == sar_pkg::ST_ACQ_EXT && !d_in[5]) begin
                state_next = sar_pkg::ST_CONV;
                track_next = 1'b0;
                sar_next   = sar_pkg::SAR_START;
                bit_next   = sar_pkg::SAR_START;
            end else begin
                aborted    = (state_reg == sar_pkg::ST_CONV);
                track_next = 1'b1;
                state_next = d_in[5] ? sar_pkg::ST_ACQ_EXT
                                     : sar_pkg::ST_ACQ_INT;
            end
        end else begin
            unique case (state_reg)
                sar_pkg::ST_IDLE, sar_pkg::ST_ACQ_EXT: begin
                end
                sar_pkg::ST_ACQ_INT: begin
                    if (tick) begin
                        cnt_next = CNT_W'(cnt_reg + 1'b1);
                        if (cnt_reg == CNT_W'(ACQ_FALL_EDGES - 1)) begin
                            state_next = sar_pkg::ST_CONV;
                            track_next = 1'b0;
                            cnt_next   = '0;
                            sar_next   = sar_pkg::SAR_START;
                            bit_next   = sar_pkg::SAR_START;
                        end
                    end
                end
                sar_pkg::ST_CONV: begin
                    if (tick) begin
                        cnt_next = CNT_W'(cnt_reg + 1'b1);
                        if (cnt_reg < CNT_W'(sar_pkg::RESULT_BITS)) begin
                            sar_next = (comp_in ? sar_reg : sar_reg & ~bit_reg)
                                       | (bit_reg >> 1);
                            bit_next = bit_reg >> 1;
                        end
                        if (cnt_reg == CNT_W'(CONV_CYCLES - 1)) begin
                            result_next = sar_reg;
                            conv_done   = 1'b1;
                            state_next  = sar_pkg::ST_IDLE;
                            cnt_next    = '0;
                        end
                    end
                end
            endcase
        end
        // completion wins over a clearing strobe
        done_n_next = conv_done ? 1'b0 :
                      (wr_rise || rd_fall) ? 1'b1 : done_n_reg;
    end

    // Sequencer registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg   <= sar_pkg::ST_IDLE;
            ctl_reg     <= sar_pkg::ctl_byte_t'(sar_pkg::CTL_RST);
            cnt_reg     <= '0;
            div_reg     <= '0;
            sar_reg     <= '0;
            bit_reg     <= '0;
            result_reg  <= '0;
            clk_ext_reg <= 1'b1;
            track_reg   <= 1'b0;
            done_n_reg  <= 1'b1;
            wr_n_q_reg  <= 1'b1;
            rd_n_q_reg  <= 1'b1;
            cclk_q_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            ctl_reg     <= ctl_next;
            cnt_reg     <= cnt_next;
            div_reg     <= div_next;
            sar_reg     <= sar_next;
            bit_reg     <= bit_next;
            result_reg  <= result_next;
            clk_ext_reg <= clk_ext_next;
            track_reg   <= track_next;
            done_n_reg  <= done_n_next;
            wr_n_q_reg  <= wr_n;
            rd_n_q_reg  <= rd_n;
            cclk_q_reg  <= conv_clk_in;
        end
    end

    logic [7:0]      d_out_reg;
    logic            d_oe_reg, done_oe_reg, pol_reg;
    sar_pkg::route_t route_reg;

    // Host bus and analog outputs; data is registered so it lags by a cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            d_out_reg   <= '0;
            d_oe_reg    <= 1'b0;
            done_oe_reg <= 1'b0;
            route_reg   <= '0;
            pol_reg     <= 1'b0;
        end else begin
            d_out_reg   <= high_byte_select ?
                           {6'h00, result_next[9:sar_pkg::LOW_BITS]} :
                           result_next[sar_pkg::LOW_BITS-1:0];
            d_oe_reg    <= ~cs_n & ~rd_n;
            done_oe_reg <= ~cs_n;
            route_reg   <= route_of(ctl_next);
            pol_reg     <= ctl_next.polarity_select;
        end
    end

    assign d_out           = d_out_reg;
    assign d_oe            = d_oe_reg;
    assign done_n          = done_n_reg;
    assign done_oe         = done_oe_reg;
    assign track           = track_reg;
    assign route           = route_reg;
    assign polarity_select = pol_reg;
    assign dac_code        = sar_reg;

    logic [3:0]                  awaddr_reg, awaddr_next;
    logic                        aw_have_reg, aw_have_next;
    logic                        w_have_reg, w_have_next;
    logic [31:0]                 wdata_reg, wdata_next;
    logic                        wstrb0_reg, wstrb0_next;
    logic                        bvalid_reg, bvalid_next, arready_reg;
    logic                        arready_next, rvalid_reg, rvalid_next;
    logic [1:0]                  bresp_reg, bresp_next, rresp_reg;
    logic [1:0]                  rresp_next;
    logic [31:0]                 rdata_reg, rdata_next;
    logic [sar_pkg::STATUS_W-1:0] status_reg, status_next;
    logic [sar_pkg::STATUS_W-1:0] mask_reg, mask_next, clr;
    logic                        irq_reg, irq_next, do_write;

    // Register slave: address and data in either order, one-cycle answer.
    always_comb begin
        aw_have_next = aw_have_reg;
        awaddr_next  = awaddr_reg;
        w_have_next  = w_have_reg;
        wdata_next   = wdata_reg;
        wstrb0_next  = wstrb0_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        mask_next    = mask_reg;
        clr          = '0;
        if (s_axi_awvalid && !aw_have_reg) begin
            aw_have_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_reg) begin
            w_have_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb0_next = s_axi_wstrb[0];
        end
        do_write = aw_have_next && w_have_next && !bvalid_next;
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = sar_pkg::RESP_OKAY;
            if (awaddr_next == sar_pkg::STATUS_OFS) begin
                clr = wstrb0_next ? wdata_next[1:0] : '0;
            end else if (awaddr_next == sar_pkg::MASK_OFS) begin
                mask_next = wstrb0_next ? wdata_next[1:0] : mask_reg;
            end else begin
                bresp_next = sar_pkg::RESP_SLVERR;
            end
        end
        // Events set sticky bits; a set in the clearing cycle survives.
        status_next = (status_reg & ~clr) | {aborted, conv_done};
        irq_next    = |(status_next & mask_next);
        rvalid_next  = rvalid_reg;
        arready_next = arready_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next  = 1'b0;
            arready_next = 1'b1;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next  = 1'b1;
            arready_next = 1'b0;
            rresp_next   = sar_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                sar_pkg::STATUS_OFS:  rdata_next = {30'h0, status_reg};
                sar_pkg::MASK_OFS:    rdata_next = {30'h0, mask_reg};
                sar_pkg::RESULT_OFS: begin
                    rdata_next = {22'h0, result_reg};
                    rdata_next[sar_pkg::BUSY_BIT]  =
                        (state_reg != sar_pkg::ST_IDLE);
                    rdata_next[sar_pkg::TRACK_BIT] = track_reg;
                end
                sar_pkg::CONTROL_OFS: rdata_next = {24'h0, ctl_reg};
                default: begin
                    rdata_next = '0;
                    rresp_next = sar_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Register slave and interrupt state.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_have_reg <= 1'b0;
            awaddr_reg  <= '0;
            w_have_reg  <= 1'b0;
            wdata_reg   <= '0;
            wstrb0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= sar_pkg::RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= sar_pkg::RESP_OKAY;
            status_reg  <= '0;
            mask_reg    <= sar_pkg::MASK_RST;
            irq_reg     <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            awaddr_reg  <= awaddr_next;
            w_have_reg  <= w_have_next;
            wdata_reg   <= wdata_next;
            wstrb0_reg  <= wstrb0_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            status_reg  <= status_next;
            mask_reg    <= mask_next;
            irq_reg     <= irq_next;
        end
    end

    assign s_axi_awready = ~aw_have_reg;
    assign s_axi_wready  = ~w_have_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = irq_reg;

    // Helper: conversion clock ticks seen since the conversion began.
    logic [4:0] conv_ticks_reg;
    always_ff @(posedge clk_sys) begin
        if (rst || state_reg != sar_pkg::ST_CONV) begin
            conv_ticks_reg <= '0;
        end else if (tick) begin
            conv_ticks_reg <= 5'(conv_ticks_reg + 1'b1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence conv_finish_s;
        state_reg == sar_pkg::ST_CONV ##1 state_reg == sar_pkg::ST_IDLE;
    endsequence
    sequence ext_end_s;
        wr_rise && state_reg == sar_pkg::ST_ACQ_EXT && !d_in[5];
    endsequence

    AST_TRACK_ON_WRITE: assert property (
        wr_rise && !(state_reg == sar_pkg::ST_ACQ_EXT && !d_in[5])
        |=> track_reg ##1 track)
        else $error("track did not start after write");
    AST_EXT_HOLD: assert property (
        ext_end_s |=> !track_reg && state_reg == sar_pkg::ST_CONV)
        else $error("external acquisition did not end on write");
    AST_INT_HOLD: assert property (
        state_reg == sar_pkg::ST_ACQ_INT && tick && !wr_rise &&
        cnt_reg == CNT_W'(ACQ_FALL_EDGES - 1)
        |=> state_reg == sar_pkg::ST_CONV && !track_reg)
        else $error("internal acquisition hold edge wrong");
    AST_CONV_LEN: assert property (
        conv_finish_s |-> $past(conv_ticks_reg) == 5'(CONV_CYCLES - 1))
        else $error("conversion did not last thirteen clocks");
    AST_ABORT: assert property (
        wr_rise && state_reg == sar_pkg::ST_CONV
        |=> state_reg != sar_pkg::ST_CONV && track_reg
            && status_reg[sar_pkg::ST_ABORT_BIT])
        else $error("write did not abort conversion");
    AST_DONE_SET: assert property (
        conv_finish_s |-> !done_n && $past(done_n, 2))
        else $error("done not raised at completion");
    AST_DONE_CLR: assert property (
        rd_fall && !conv_done |=> done_n)
        else $error("read did not clear done");
    AST_BYTE_SEL: assert property (
        high_byte_select ##1 1'b1 |-> d_out[7:2] == 6'h00
        && d_out[1:0] == result_reg[9:8])
        else $error("high byte select did not show top bits");
    AST_ROUTE: assert property (
        route.neg_com == ctl_reg.single_ended && route.pos == ctl_reg.chan)
        else $error("input routing does not follow control byte");
    AST_RESULT_KEEP: assert property (
        state_reg != sar_pkg::ST_CONV ##1 state_reg != sar_pkg::ST_CONV
        |-> $stable(result_reg))
        else $error("result changed without a completed conversion");

endmodule : sar_acq_ctrl

// ---- verilog/sar_pkg.sv ----
// Constants, field layouts and types of the converter sequencer.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package sar_pkg;

    // System clock period and conversion timing.
    localparam int CLK_PERIOD_NS      = 10;
    localparam int CONV_CYCLES        = 13;
    localparam int ACQ_FALL_EDGES     = 4;
    localparam int INT_CONV_TIME_NS   = 3600;
    // Internal conversion clock period in system clocks, rounded down.
    localparam int INT_TICK_CYCLES    =
        INT_CONV_TIME_NS / CONV_CYCLES / CLK_PERIOD_NS;

    // Result layout.
    localparam int RESULT_BITS        = 10;
    localparam int LOW_BITS           = 8;

    // Control byte clock-mode codes in the two top bits.
    localparam logic [1:0] CLK_INT_CODE = 2'h2;
    localparam logic [1:0] CLK_EXT_CODE = 2'h3;

    // Register map (byte addresses) and field positions.
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  STATUS_OFS   = 4'h0;
    localparam logic [3:0]  MASK_OFS     = 4'h4;
    localparam logic [3:0]  RESULT_OFS   = 4'h8;
    localparam logic [3:0]  CONTROL_OFS  = 4'hC;
    localparam int          ST_DONE_BIT  = 0;
    localparam int          ST_ABORT_BIT = 1;
    localparam int          STATUS_W     = 2;
    localparam int          BUSY_BIT     = 16;
    localparam int          TRACK_BIT    = 17;

    // Reset values; power-up selects the external conversion clock.
    localparam logic [1:0]  MASK_RST     = 2'h0;
    localparam logic [7:0]  CTL_RST      = 8'hC0;
    localparam logic [9:0]  SAR_START    = 10'h200;

    // Bus responses.
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Sequencer phases.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ_EXT,
        ST_ACQ_INT,
        ST_CONV
    } state_t;

    // Control byte as written by the host.
    typedef struct packed {
        logic [1:0] pd;
        logic       acquisition_mode_select;
        logic       single_ended;
        logic       polarity_select;
        logic [2:0] chan;
    } ctl_byte_t;

    // Input multiplexer routing for the sampling capacitor.
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic       neg_com;
    } route_t;

endpackage : sar_pkg
